// *** include/agparc_map.svh ***
// Register map, field positions and reset values of the graphics port rate control
`ifndef AGPARC_MAP_SVH
`define AGPARC_MAP_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define AGPARC_OFS_BASE 8'h10
`define AGPARC_OFS_CMD 8'hA8
`define AGPARC_OFS_CTRL 8'hB0
`define AGPARC_OFS_SIZE 8'hB4

// ****************************************************
// Field positions
// ****************************************************
`define AGPARC_RATE_HI 2
`define AGPARC_RATE_LO 0
`define AGPARC_FASTWR_BIT 4
`define AGPARC_TLBEN_BIT 7
`define AGPARC_MASK_HI 5
`define AGPARC_MASK_LO 0
`define AGPARC_BASE_HI 27
`define AGPARC_BASE_LO 22

// ****************************************************
// Encodings and reset values
// ****************************************************
`define AGPARC_RATE_1X 3'h1
`define AGPARC_RATE_2X 3'h2
`define AGPARC_RATE_4X 3'h4
`define AGPARC_RATE_RST 3'h0
`define AGPARC_MASK_RST 6'h00
`define AGPARC_MASK_4MB 6'h3F
`define AGPARC_MASK_8MB 6'h3E
`define AGPARC_MASK_16MB 6'h3C
`define AGPARC_MASK_32MB 6'h38
`define AGPARC_MASK_64MB 6'h30
`define AGPARC_MASK_128MB 6'h20
`define AGPARC_SIZE_MAX_MB 9'h100
`define AGPARC_TLB_ENTRIES 8

`endif

// *** include/agparc_pkg.sv ***
// Types shared by both ends of the graphics port rate control
package agparc_pkg;
   typedef logic [2:0] agparc_rate_t;
   typedef logic [5:0] agparc_mask_t;
   typedef logic [7:0] agparc_addr_t;
   typedef logic [31:0] agparc_word_t;
   typedef enum {AGPARC_IDLE, AGPARC_WAIT} agparc_state_t;
endpackage : agparc_pkg

// *** include/agparc_if.sv ***
// Configuration access link between software end and device end
`timescale 1ns/1ps
interface agparc_if;
   logic cfg_wr;
   logic cfg_rd;
   agparc_pkg::agparc_addr_t cfg_addr;
   agparc_pkg::agparc_word_t cfg_wdata;
   agparc_pkg::agparc_word_t cfg_rdata;
   logic cfg_ack;

   modport dev (input cfg_wr, input cfg_rd, input cfg_addr, input cfg_wdata,
      output cfg_rdata, output cfg_ack);
   modport sw (output cfg_wr, output cfg_rd, output cfg_addr, output cfg_wdata,
      input cfg_rdata, input cfg_ack);
endinterface : agparc_if

// *** hw/agparc_dev.sv ***
// Device end: rate select, translation buffer control and aperture size mask
`timescale 1ns/1ps
`include "agparc_map.svh"

module agparc_dev (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   agparc_if.dev bus,
   input wire logic tlb_fill_in,
   input wire logic [2:0] tlb_fill_idx_in,
   output logic [2:0] ad_sba_rate_out,
   output logic [2:0] fast_write_rate_out,
   output logic std_write_out,
   output logic tlb_enable_out,
   output logic [7:0] tlb_valid_out,
   output agparc_pkg::agparc_mask_t aperture_size_mask_out,
   output logic [5:0] aperture_base_out,
   output logic [8:0] aperture_size_mb_out
);
   import agparc_pkg::*;

   // ****************************************************
   // Register state
   // ****************************************************
   agparc_rate_t transfer_rate_select;
   logic fast_write_enable;
   logic tlb_enable;
   agparc_mask_t aperture_size_mask;
   logic [5:0] aperture_base;
   logic [`AGPARC_TLB_ENTRIES-1:0] tlb_valid;
   agparc_word_t rdata;
   logic ack;
   logic [2:0] ad_sba_rate;
   logic [2:0] fw_rate;
   logic std_write;
   logic [8:0] size_mb;

   agparc_rate_t next_transfer_rate_select;
   logic next_fast_write_enable;
   logic next_tlb_enable;
   agparc_mask_t next_aperture_size_mask;
   logic [5:0] next_aperture_base;
   logic [`AGPARC_TLB_ENTRIES-1:0] next_tlb_valid;
   agparc_word_t next_rdata;
   logic next_ack;
   logic [2:0] next_ad_sba_rate;
   logic [2:0] next_fw_rate;
   logic next_std_write;
   logic [8:0] next_size_mb;

   // ****************************************************
   // Configuration writes
   // ****************************************************
   // Register updates from software writes
   always_comb
   begin
      next_transfer_rate_select = transfer_rate_select;
      next_fast_write_enable = fast_write_enable;
      next_tlb_enable = tlb_enable;
      next_aperture_size_mask = aperture_size_mask;
      next_aperture_base = aperture_base;
      if (bus.cfg_wr)
      begin
         case (bus.cfg_addr)
            `AGPARC_OFS_CMD:
            begin
               // Stored as written; software keeps it one-hot
               next_transfer_rate_select =
                  bus.cfg_wdata[`AGPARC_RATE_HI:`AGPARC_RATE_LO];
               next_fast_write_enable = bus.cfg_wdata[`AGPARC_FASTWR_BIT];
            end
            `AGPARC_OFS_CTRL: next_tlb_enable = bus.cfg_wdata[`AGPARC_TLBEN_BIT];
            `AGPARC_OFS_SIZE:
            begin
               next_aperture_size_mask =
                  bus.cfg_wdata[`AGPARC_MASK_HI:`AGPARC_MASK_LO];
            end
            `AGPARC_OFS_BASE:
            begin
               next_aperture_base =
                  bus.cfg_wdata[`AGPARC_BASE_HI:`AGPARC_BASE_LO];
            end
            default: next_aperture_base = aperture_base;
         endcase
      end
      // Cleared mask bits hold base bits at zero, any pattern
      next_aperture_base = next_aperture_base & next_aperture_size_mask;
   end

   // Register file flops, all zero from reset
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         transfer_rate_select <= `AGPARC_RATE_RST;
         fast_write_enable <= 1'b0;
         tlb_enable <= 1'b0;
         aperture_size_mask <= `AGPARC_MASK_RST;
         aperture_base <= 6'h00;
      end
      else
      begin
         transfer_rate_select <= next_transfer_rate_select;
         fast_write_enable <= next_fast_write_enable;
         tlb_enable <= next_tlb_enable;
         aperture_size_mask <= next_aperture_size_mask;
         aperture_base <= next_aperture_base;
      end
   end

   // ****************************************************
   // Configuration reads
   // ****************************************************
   // Read data with reserved bits at zero, one-cycle acknowledge
   always_comb
   begin
      next_rdata = 32'h00000000;
      next_ack = bus.cfg_wr | bus.cfg_rd;
      if (bus.cfg_rd)
      begin
         case (bus.cfg_addr)
            `AGPARC_OFS_CMD:
            begin
               next_rdata[`AGPARC_RATE_HI:`AGPARC_RATE_LO] = transfer_rate_select;
               next_rdata[`AGPARC_FASTWR_BIT] = fast_write_enable;
            end
            `AGPARC_OFS_CTRL: next_rdata[`AGPARC_TLBEN_BIT] = tlb_enable;
            `AGPARC_OFS_SIZE: next_rdata[`AGPARC_MASK_HI:`AGPARC_MASK_LO] = aperture_size_mask;
            `AGPARC_OFS_BASE: next_rdata[`AGPARC_BASE_HI:`AGPARC_BASE_LO] = aperture_base;
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // Read answer flops
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         rdata <= 32'h00000000;
         ack <= 1'b0;
      end
      else
      begin
         rdata <= next_rdata;
         ack <= next_ack;
      end
   end

   // ****************************************************
   // Translation buffer valid bits
   // ****************************************************
   // Fill sets a valid bit; disabled buffer clears them all
   always_comb
   begin
      next_tlb_valid = tlb_valid;
      if (!tlb_enable)
      begin
         next_tlb_valid = '0;
      end
      else if (tlb_fill_in)
      begin
         next_tlb_valid[tlb_fill_idx_in] = 1'b1;
      end
   end

   // Valid bit flops
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         tlb_valid <= '0;
      end
      else
      begin
         tlb_valid <= next_tlb_valid;
      end
   end

   // ****************************************************
   // Port steering
   // ****************************************************
   // Rate decode, fast write choice and aperture size
   always_comb
   begin
      case (transfer_rate_select)
         `AGPARC_RATE_1X: next_ad_sba_rate = `AGPARC_RATE_1X;
         `AGPARC_RATE_2X: next_ad_sba_rate = `AGPARC_RATE_2X;
         `AGPARC_RATE_4X: next_ad_sba_rate = `AGPARC_RATE_4X;
         default: next_ad_sba_rate = 3'h0; // No legal rate chosen
      endcase
      // Fast writes only above 1x and when enabled
      if (fast_write_enable && (next_ad_sba_rate == `AGPARC_RATE_2X ||
         next_ad_sba_rate == `AGPARC_RATE_4X))
      begin
         next_fw_rate = next_ad_sba_rate;
         next_std_write = 1'b0;
      end
      else
      begin
         next_fw_rate = 3'h0;
         next_std_write = 1'b1;
      end
      // Each set mask bit halves the aperture
      next_size_mb = `AGPARC_SIZE_MAX_MB;
      for (int i = 0; i < 6; i++)
      begin
         if (aperture_size_mask[i])
         begin
            next_size_mb = next_size_mb >> 1;
         end
      end
   end

   // Steering output flops
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ad_sba_rate <= 3'h0;
         fw_rate <= 3'h0;
         std_write <= 1'b1;
         size_mb <= `AGPARC_SIZE_MAX_MB;
      end
      else
      begin
         ad_sba_rate <= next_ad_sba_rate;
         fw_rate <= next_fw_rate;
         std_write <= next_std_write;
         size_mb <= next_size_mb;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign bus.cfg_rdata = rdata;
   assign bus.cfg_ack = ack;
   assign ad_sba_rate_out = ad_sba_rate;
   assign fast_write_rate_out = fw_rate;
   assign std_write_out = std_write;
   assign tlb_enable_out = tlb_enable;
   assign tlb_valid_out = tlb_valid;
   assign aperture_size_mask_out = aperture_size_mask;
   assign aperture_base_out = aperture_base;
   assign aperture_size_mb_out = size_mb;

endmodule : agparc_dev

// *** hw/agparc_sw.sv ***
// Software end: configuration master that guards rate and mask settings
`timescale 1ns/1ps
`include "agparc_map.svh"

module agparc_sw (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   agparc_if.sw bus,
   input wire logic user_req_in,
   input wire logic user_wr_in,
   input wire agparc_pkg::agparc_addr_t user_addr_in,
   input wire agparc_pkg::agparc_word_t user_wdata_in,
   input wire agparc_pkg::agparc_rate_t user_cap_in,
   output agparc_pkg::agparc_word_t user_rdata_out,
   output logic user_done_out,
   output logic user_refused_out
);
   import agparc_pkg::*;

   // ****************************************************
   // State
   // ****************************************************
   agparc_state_t state;
   agparc_state_t next_state;
   logic cfg_wr, next_cfg_wr;
   logic cfg_rd, next_cfg_rd;
   agparc_addr_t cfg_addr, next_cfg_addr;
   agparc_word_t cfg_wdata, next_cfg_wdata;
   agparc_word_t rdata, next_rdata;
   logic done, next_done;
   logic refused, next_refused;
   logic mask_set, next_mask_set;
   logic legal;
   agparc_rate_t rate;
   agparc_mask_t mask;

   // Request checks, issue and completion
   always_comb
   begin
      next_state = state;
      next_cfg_wr = 1'b0;
      next_cfg_rd = 1'b0;
      next_cfg_addr = cfg_addr;
      next_cfg_wdata = cfg_wdata;
      next_rdata = rdata;
      next_done = 1'b0;
      next_refused = 1'b0;
      next_mask_set = mask_set;
      rate = user_wdata_in[`AGPARC_RATE_HI:`AGPARC_RATE_LO];
      mask = user_wdata_in[`AGPARC_MASK_HI:`AGPARC_MASK_LO];
      legal = 1'b1;
      if (user_wr_in && user_addr_in == `AGPARC_OFS_CMD)
      begin
         // One-hot and supported by the master
         legal = (rate == `AGPARC_RATE_1X || rate == `AGPARC_RATE_2X ||
            rate == `AGPARC_RATE_4X) && ((rate & user_cap_in) != 3'h0);
      end
      else if (user_wr_in && user_addr_in == `AGPARC_OFS_SIZE)
      begin
         // Listed patterns only, never the maximum
         legal = (mask == `AGPARC_MASK_4MB || mask == `AGPARC_MASK_8MB ||
            mask == `AGPARC_MASK_16MB || mask == `AGPARC_MASK_32MB ||
            mask == `AGPARC_MASK_64MB || mask == `AGPARC_MASK_128MB);
      end
      else if (user_wr_in && user_addr_in == `AGPARC_OFS_BASE)
      begin
         legal = mask_set; // Mask before base programming
      end
      case (state)
         AGPARC_IDLE:
         begin
            if (user_req_in && !legal)
            begin
               next_done = 1'b1;
               next_refused = 1'b1;
            end
            else if (user_req_in)
            begin
               next_cfg_wr = user_wr_in;
               next_cfg_rd = !user_wr_in;
               next_cfg_addr = user_addr_in;
               next_cfg_wdata = user_wdata_in;
               if (user_wr_in && user_addr_in == `AGPARC_OFS_SIZE)
               begin
                  next_mask_set = 1'b1;
               end
               next_state = AGPARC_WAIT;
            end
         end
         AGPARC_WAIT:
         begin
            if (bus.cfg_ack)
            begin
               next_rdata = bus.cfg_rdata;
               next_done = 1'b1;
               next_state = AGPARC_IDLE;
            end
         end
         default:
         begin
            next_state = AGPARC_IDLE;
         end
      endcase
   end

   // Master flops
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state <= AGPARC_IDLE;
         cfg_wr <= 1'b0;
         cfg_rd <= 1'b0;
         cfg_addr <= 8'h00;
         cfg_wdata <= 32'h00000000;
         rdata <= 32'h00000000;
         done <= 1'b0;
         refused <= 1'b0;
         mask_set <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cfg_wr <= next_cfg_wr;
         cfg_rd <= next_cfg_rd;
         cfg_addr <= next_cfg_addr;
         cfg_wdata <= next_cfg_wdata;
         rdata <= next_rdata;
         done <= next_done;
         refused <= next_refused;
         mask_set <= next_mask_set;
      end
   end

   // Outputs
   assign bus.cfg_wr = cfg_wr;
   assign bus.cfg_rd = cfg_rd;
   assign bus.cfg_addr = cfg_addr;
   assign bus.cfg_wdata = cfg_wdata;
   assign user_rdata_out = rdata;
   assign user_done_out = done;
   assign user_refused_out = refused;

endmodule : agparc_sw

// *** dv/agparc_sva.sv ***
// Link protocol and steering checks for the graphics port rate control
`timescale 1ns/1ps
module agparc_sva (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire agparc_pkg::agparc_word_t cfg_rdata,
   input wire logic cfg_ack,
   input wire logic [2:0] ad_sba_rate_out,
   input wire logic [2:0] fast_write_rate_out,
   input wire logic std_write_out,
   input wire logic tlb_enable_out,
   input wire logic [7:0] tlb_valid_out,
   input wire agparc_pkg::agparc_mask_t aperture_size_mask_out,
   input wire logic [5:0] aperture_base_out,
   input wire logic [8:0] aperture_size_mb_out
);
   import agparc_pkg::*;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   // ****************************************************
   // Assertions
   // ****************************************************
   a_ack_one_pulse: assert property ((cfg_wr || cfg_rd) |=> cfg_ack ##1 !cfg_ack)
      else $error("ack missing or too long");
   a_ack_has_cause: assert property (cfg_ack |-> $past(cfg_wr || cfg_rd))
      else $error("ack without strobe");
   a_rdata_idle_zero: assert property (!cfg_ack |-> cfg_rdata == 32'h0)
      else $error("read data outside ack");
   a_rate_one_hot: assert property ($onehot0(ad_sba_rate_out))
      else $error("rate not one-hot");
   a_fast_at_rate: assert property (fast_write_rate_out != 3'h0 |->
      fast_write_rate_out == ad_sba_rate_out && fast_write_rate_out != 3'h1)
      else $error("fast write rate wrong");
   a_std_write_excl: assert property (std_write_out == (fast_write_rate_out == 3'h0))
      else $error("write protocol mismatch");
   a_tlb_flush_off: assert property (!tlb_enable_out [*2] |-> tlb_valid_out == 8'h00)
      else $error("valid bits kept while disabled");
   a_base_masked: assert property ($past(aperture_size_mask_out, 2) == aperture_size_mask_out
      |-> (aperture_base_out & ~aperture_size_mask_out) == 6'h00)
      else $error("base bit set under zero mask");
   a_size_from_mask: assert property ($past(aperture_size_mask_out, 2) == aperture_size_mask_out
      && $past(aperture_size_mask_out) == aperture_size_mask_out
      |-> aperture_size_mb_out == (9'h100 >> $countones(aperture_size_mask_out)))
      else $error("aperture size wrong");
endmodule : agparc_sva

// *** dv/tb_agp_aperture_rate_control.sv ***
// Self-checking bench joining the software and device ends
`timescale 1ns/1ps
`include "agparc_map.svh"
module tb_agp_aperture_rate_control;
   import agparc_pkg::*;
   logic mclk_in, sys_rst_in, req, wr, fill, done, refused, std_wr, tlb_en;
   logic [2:0] fidx, ad_rate, fw_rate;
   agparc_addr_t addr;
   agparc_word_t wdata, rdata, d;
   agparc_rate_t cap;
   logic [7:0] tlb_vld;
   agparc_mask_t mask;
   logic [5:0] base;
   logic [8:0] size_mb;
   int err_total, n_checks, rate_m, fw_m, tlb_m, mask_m, base_m, vld_m;
   int masks[$] = '{6'h3F, 6'h3E, 6'h3C, 6'h38, 6'h30, 6'h20};
   int regs[$] = '{8'hA8, 8'hB0, 8'hB4, 8'h10, 8'h40};

   agparc_if ifc ();
   agparc_dev agparc_dev_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus(ifc),
      .tlb_fill_in(fill), .tlb_fill_idx_in(fidx), .ad_sba_rate_out(ad_rate),
      .fast_write_rate_out(fw_rate), .std_write_out(std_wr), .tlb_enable_out(tlb_en),
      .tlb_valid_out(tlb_vld), .aperture_size_mask_out(mask), .aperture_base_out(base),
      .aperture_size_mb_out(size_mb));
   agparc_sw agparc_sw_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus(ifc),
      .user_req_in(req), .user_wr_in(wr), .user_addr_in(addr), .user_wdata_in(wdata),
      .user_cap_in(cap), .user_rdata_out(rdata), .user_done_out(done),
      .user_refused_out(refused));
   agparc_sva agparc_sva_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .cfg_wr(ifc.cfg_wr), .cfg_rd(ifc.cfg_rd), .cfg_rdata(ifc.cfg_rdata),
      .cfg_ack(ifc.cfg_ack), .ad_sba_rate_out(ad_rate), .fast_write_rate_out(fw_rate),
      .std_write_out(std_wr), .tlb_enable_out(tlb_en), .tlb_valid_out(tlb_vld),
      .aperture_size_mask_out(mask), .aperture_base_out(base),
      .aperture_size_mb_out(size_mb));

   // ****************************************************
   // Compare, verdict and model
   // ****************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   function automatic logic [31:0] model_rd(input int a);
      case (a)
         `AGPARC_OFS_CMD: return 32'(rate_m | (fw_m << 4));
         `AGPARC_OFS_CTRL: return 32'(tlb_m << 7);
         `AGPARC_OFS_SIZE: return 32'(mask_m);
         `AGPARC_OFS_BASE: return 32'(base_m << 22);
         default: return 32'h0;
      endcase
   endfunction : model_rd

   // One user request, bounded wait for completion
   task automatic op(input logic w, input int a, input agparc_word_t v, input logic exp_ref);
      int n;
      @(posedge mclk_in);
      #1;
      req = 1'b1;
      wr = w;
      addr = 8'(a);
      wdata = v;
      @(posedge mclk_in);
      #1;
      req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20)
      begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      chk(done, 1'b1);
      chk(refused, exp_ref);
   endtask : op

   task automatic rd_chk(input int a);
      op(1'b0, a, $urandom, 1'b0);
      chk(rdata, model_rd(a));
   endtask : rd_chk

   // Device steering outputs against the model
   task automatic chk_out();
      int f;
      f = (fw_m == 1 && rate_m > 1) ? rate_m : 0;
      chk(ad_rate, rate_m);
      chk(fw_rate, f);
      chk(std_wr, f == 0);
      chk(tlb_en, tlb_m);
      chk(mask, mask_m);
      chk(base, base_m);
      chk(size_mb, 256 >> $countones(mask_m));
      chk(tlb_vld, vld_m);
   endtask : chk_out

   task automatic fill_one(input logic [2:0] i);
      @(posedge mclk_in);
      #1;
      fill = 1'b1;
      fidx = i;
      @(posedge mclk_in);
      #1;
      fill = 1'b0;
      if (tlb_m == 1)
         vld_m |= 1 << i;
      chk(tlb_vld, vld_m);
   endtask : fill_one

   task automatic do_reset();
      sys_rst_in = 1'b1;
      {rate_m, fw_m, tlb_m, mask_m, base_m, vld_m} = '0;
      repeat (3) @(posedge mclk_in);
      #1;
      sys_rst_in = 1'b0;
      chk_out();
   endtask : do_reset

   // ****************************************************
   // Clock, watchdog and tests
   // ****************************************************
   initial
   begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end

   initial
   begin
      #300000;
      err_total++;
      tally_and_finish();
   end

   initial
   begin
      {req, wr, fill, fidx, addr, wdata, err_total, n_checks} = '0;
      cap = 3'h7;
      void'($urandom(32'h72E0F291));
      do_reset();
      foreach (regs[k]) rd_chk(regs[k]);
      op(1'b1, `AGPARC_OFS_BASE, 32'hFFFFFFFF, 1'b1);
      // Every rate pattern, fast writes on
      for (int r = 0; r < 8; r++)
      begin
         d = ($urandom & 32'hFFFFFFE8) | 32'h10 | 32'(r);
         op(1'b1, `AGPARC_OFS_CMD, d, !$onehot(r));
         if ($onehot(r))
            {rate_m, fw_m} = {r, 32'h1};
         chk_out();
         rd_chk(`AGPARC_OFS_CMD);
      end
      op(1'b1, `AGPARC_OFS_CMD, 32'h4, 1'b0);
      {rate_m, fw_m} = {32'h4, 32'h0};
      chk_out();
      cap = 3'h3;
      op(1'b1, `AGPARC_OFS_CMD, 32'h14, 1'b1);
      cap = 3'h7;
      // Buffer enable with reserved noise, fill, flush
      op(1'b1, `AGPARC_OFS_CTRL, $urandom | 32'h80, 1'b0);
      tlb_m = 1;
      rd_chk(`AGPARC_OFS_CTRL);
      repeat (3) fill_one(3'($urandom));
      op(1'b1, `AGPARC_OFS_CTRL, $urandom & 32'hFFFFFF7F, 1'b0);
      {tlb_m, vld_m} = '0;
      chk_out();
      fill_one(3'h5);
      // Every legal mask with a random base
      foreach (masks[k])
      begin
         op(1'b1, `AGPARC_OFS_SIZE, ($urandom & 32'hFFFFFFC0) | 32'(masks[k]), 1'b0);
         mask_m = masks[k];
         base_m &= mask_m;
         chk_out();
         d = $urandom;
         op(1'b1, `AGPARC_OFS_BASE, d, 1'b0);
         base_m = int'(d[27:22]) & mask_m;
         chk_out();
         rd_chk(`AGPARC_OFS_BASE);
         rd_chk(`AGPARC_OFS_SIZE);
      end
      op(1'b1, `AGPARC_OFS_SIZE, 32'h0, 1'b1);
      op(1'b1, `AGPARC_OFS_SIZE, 32'h15, 1'b1);
      chk_out();
      do_reset();
      foreach (regs[k]) rd_chk(regs[k]);
      tally_and_finish();
   end
endmodule : tb_agp_aperture_rate_control
